/* inc/acsu_op_if.sv */
/*
  Operand and result bundle between sequencer, datapath and response stage.
  Assumes all three sit on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none

interface acsu_op_if;
  import acsu_pkg::*;

  logic [ACSU_CMD_W-1:0]  cmd;
  logic                   sel_hi;
  logic [ACSU_DATA_W-1:0] mem_data;
  logic [ACSU_DATA_W-1:0] imm_data;
  logic                   known;
  logic                   wr_en;
  logic [ACSU_DATA_W-1:0] wr_data;
  logic                   flag;
  logic                   has_data;
  logic [ACSU_DATA_W-1:0] rsp_data;

  modport ctl (output cmd, sel_hi, mem_data, imm_data,
               input  known, wr_en, wr_data, flag, has_data, rsp_data);
  modport alu (input  cmd, sel_hi, mem_data, imm_data,
               output known, wr_en, wr_data, flag, has_data, rsp_data);
  modport rsp (input  known, flag, has_data, rsp_data);

endinterface

`default_nettype wire

/* inc/acsu_pkg.sv */
/*
  Constants, opcodes and state type of the atomic compare and swap unit.
  Assumes a 16-byte memory block port and 7-bit request opcodes.
*/
`default_nettype none

package acsu_pkg;

  // ----------------------------------------------------------------------
  // Widths and field positions
  // ----------------------------------------------------------------------
  localparam int unsigned ACSU_ADDR_W  = 34;
  localparam int unsigned ACSU_DATA_W  = 128;
  localparam int unsigned ACSU_HALF_W  = 64;
  localparam int unsigned ACSU_CMD_W   = 7;
  localparam int unsigned ACSU_SEL_BIT = 3;
  localparam int unsigned ACSU_BLK_LSB = 4;

  localparam logic [ACSU_BLK_LSB-1:0] ACSU_BLK_PAD  = 4'h0;
  localparam logic [ACSU_HALF_W-1:0]  ACSU_ZERO_HALF = 64'h0;
  localparam logic [ACSU_DATA_W-1:0]  ACSU_ZERO_BLK  = 128'h0;

  // ----------------------------------------------------------------------
  // Request opcodes
  // ----------------------------------------------------------------------
  localparam logic [ACSU_CMD_W-1:0] ACSU_OP_SWAP_LT16 = 7'h63;
  localparam logic [ACSU_CMD_W-1:0] ACSU_OP_EQUAL_TEST_16      = 7'h68;
  localparam logic [ACSU_CMD_W-1:0] ACSU_OP_SWAP_EQ8  = 7'h64;
  localparam logic [ACSU_CMD_W-1:0] ACSU_OP_SWAP_Z16  = 7'h65;

  // ----------------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT,
    ST_EXEC,
    ST_RESP
  } acsu_state_t;

endpackage

`default_nettype wire

/* test/acsu_mem_model.sv */
/*
  Behavioural vault memory behind the atomic compare and swap unit.
  Assumes one read at a time and a latency chosen by the bench.
*/
`timescale 1ns/1ns
`default_nettype none

module acsu_mem_model
  import acsu_pkg::*;
(
  input  wire logic                   ref_clk_i,
  input  wire logic [3:0]             lat_i,
  input  wire logic                   rd_i,
  input  wire logic                   wr_i,
  input  wire logic [ACSU_ADDR_W-1:0] addr_i,
  input  wire logic [ACSU_DATA_W-1:0] wdata_i,
  output logic [ACSU_DATA_W-1:0]      rdata_o,
  output logic                        rvalid_o
);
  // ----------------------------------------------------------------------
  // Block store, byte 0 at bits 7:0 of each aligned block
  // ----------------------------------------------------------------------
  logic [ACSU_DATA_W-1:0] mem_q [16];
  logic [3:0]             idx_q;
  logic [3:0]             cnt_q;
  logic                   pend_q;
  int                     rd_cnt;
  int                     wr_cnt;

  initial begin
    rdata_o  = 128'h0;
    rvalid_o = 1'b0;
    idx_q    = 4'h0;
    cnt_q    = 4'h0;
    pend_q   = 1'b0;
    rd_cnt   = 0;
    wr_cnt   = 0;
  end

  // ----------------------------------------------------------------------
  // Read after lat_i cycles, data line changes every cycle otherwise
  // ----------------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    rvalid_o <= 1'b0;
    rdata_o  <= ~rdata_o;
    if (rd_i) begin
      rd_cnt <= rd_cnt + 1;
      idx_q  <= addr_i[7:4];
      if (lat_i <= 4'h1) begin
        rvalid_o <= 1'b1;
        rdata_o  <= mem_q[addr_i[7:4]];
      end else begin
        pend_q <= 1'b1;
        cnt_q  <= lat_i - 4'h2;
      end
    end else if (pend_q) begin
      if (cnt_q == 4'h0) begin
        pend_q   <= 1'b0;
        rvalid_o <= 1'b1;
        rdata_o  <= mem_q[idx_q];
      end else begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
    if (wr_i) begin
      mem_q[addr_i[7:4]] <= wdata_i;
      wr_cnt             <= wr_cnt + 1;
    end
  end

endmodule // acsu_mem_model

`default_nettype wire

/* test/tb_atomic_compare_swap_unit.sv */
/*
  Self-checking bench of the atomic compare and swap unit.
  Assumes the package, interface, design and memory model compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_atomic_compare_swap_unit;
  import acsu_pkg::*;

  // ----------------------------------------------------------------------
  // Signals and rows
  // ----------------------------------------------------------------------
  typedef struct {
    logic [ACSU_CMD_W-1:0]  cmd;
    logic [ACSU_ADDR_W-1:0] addr;
    logic [3:0]             lat;
    logic [3:0]             stall;
    logic [ACSU_DATA_W-1:0] init;
    logic [ACSU_DATA_W-1:0] imm;
    logic [ACSU_DATA_W-1:0] e_data;
    logic                   e_flag;
    logic                   e_has;
    logic                   e_err;
    logic                   e_wr;
    logic [ACSU_DATA_W-1:0] e_mem;
  } acsu_row_t;

  logic                   ref_clk_i, rst_i, req_valid_i, req_ready_o;
  logic [ACSU_CMD_W-1:0]  req_cmd_i;
  logic [ACSU_ADDR_W-1:0] req_addr_i, mem_addr_o;
  logic [ACSU_DATA_W-1:0] req_data_i, mem_wdata_o, mem_rdata_i, rsp_data_o;
  logic                   mem_rd_o, mem_wr_o, mem_lock_o, mem_rvalid_i;
  logic                   rsp_valid_o, rsp_flag_o, rsp_has_data_o;
  logic                   rsp_err_o, rsp_ready_i;
  logic [3:0]             lat;
  acsu_row_t              rows [12];
  acsu_row_t              cut;
  int                     fail_count = 0;
  int                     checks = 0;
  int                     cyc = 0;

  acsu_top dut_u (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
    .req_cmd_i(req_cmd_i), .req_addr_i(req_addr_i),
    .req_data_i(req_data_i), .req_ready_o(req_ready_o),
    .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_lock_o(mem_lock_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .mem_rdata_i(mem_rdata_i), .mem_rvalid_i(mem_rvalid_i),
    .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
    .rsp_flag_o(rsp_flag_o), .rsp_has_data_o(rsp_has_data_o),
    .rsp_err_o(rsp_err_o), .rsp_ready_i(rsp_ready_i)
  );

  acsu_mem_model u_mem (
    .ref_clk_i(ref_clk_i), .lat_i(lat), .rd_i(mem_rd_o), .wr_i(mem_wr_o),
    .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i),
    .rvalid_o(mem_rvalid_i)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic give_verdict();
    if (fail_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic tick();
    @(posedge ref_clk_i);
    #1;
  endtask

  task automatic chk(input string nm, input logic [127:0] e,
                     input logic [127:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic do_reset();
    rst_i = 1'b1;
    repeat (3) tick();
    rst_i = 1'b0;
    chk("reset_ctl", 8'h80, {req_ready_o, mem_rd_o, mem_wr_o, mem_lock_o,
        rsp_valid_o, rsp_flag_o, rsp_has_data_o, rsp_err_o});
    chk("reset_data", 128'h0, rsp_data_o);
  endtask

  task automatic run_row(input acsu_row_t r);
    int n;
    int rd0;
    int wr0;
    lat = r.lat;
    u_mem.mem_q[r.addr[7:4]] = r.init;
    rd0 = u_mem.rd_cnt;
    wr0 = u_mem.wr_cnt;
    req_valid_i = 1'b1;
    req_cmd_i = r.cmd;
    req_addr_i = r.addr;
    req_data_i = r.imm;
    n = 0;
    while (req_ready_o !== 1'b1 && n < 50) begin
      tick();
      n++;
    end
    tick();
    req_valid_i = 1'b0;
    req_cmd_i = ~r.cmd;
    req_data_i = ~r.imm;
    n = 0;
    while (rsp_valid_o !== 1'b1 && n < 50) begin
      tick();
      n++;
    end
    chk("rsp_latency", 128'(r.e_err ? 1 : 2 + r.lat), 128'(n));
    if (!r.e_err) chk("mem_addr", {r.addr[33:4], 4'h0}, mem_addr_o);
    for (int i = 0; i <= r.stall; i++) begin
      chk("rsp_data", r.e_data, rsp_data_o);
      chk("rsp_flags", {r.e_flag, r.e_has, r.e_err, 1'b1},
          {rsp_flag_o, rsp_has_data_o, rsp_err_o, rsp_valid_o});
      chk("lock_busy", {~r.e_err, 1'b0}, {mem_lock_o, req_ready_o});
      if (i == r.stall) rsp_ready_i = 1'b1;
      tick();
    end
    rsp_ready_i = 1'b0;
    chk("after_take", 3'b100, {req_ready_o, rsp_valid_o, mem_lock_o});
    chk("mem_block", r.e_mem, u_mem.mem_q[r.addr[7:4]]);
    chk("mem_reads", 128'(!r.e_err), 128'(u_mem.rd_cnt - rd0));
    chk("mem_writes", 128'(r.e_wr), 128'(u_mem.wr_cnt - wr0));
  endtask

  // ----------------------------------------------------------------------
  // Timeout
  // ----------------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    req_valid_i = 1'b0;
    req_cmd_i = 7'h00;
    req_addr_i = 34'h0;
    req_data_i = 128'h0;
    rsp_ready_i = 1'b0;
    lat = 4'h1;
    rows = '{
      '{ACSU_OP_SWAP_LT16, 34'h19, 4'h1, 4'h0, {1'b1, 127'h0}, 128'h1,
        {1'b1, 127'h0}, 1'b1, 1'b1, 1'b0, 1'b1, 128'h1},
      '{ACSU_OP_SWAP_LT16, 34'h2a, 4'h3, 4'h2, 128'h5, {1'b1, 127'h0},
        128'h5, 1'b0, 1'b1, 1'b0, 1'b1, 128'h5},
      '{ACSU_OP_SWAP_LT16, 34'h30, 4'h2, 4'h0, 128'h7, 128'h7,
        128'h7, 1'b0, 1'b1, 1'b0, 1'b1, 128'h7},
      '{ACSU_OP_EQUAL_TEST_16, 34'h4f, 4'h1, 4'h1, {64'hbeef, 64'h1}, {64'hbeef, 64'h1},
        128'h0, 1'b1, 1'b0, 1'b0, 1'b0, {64'hbeef, 64'h1}},
      '{ACSU_OP_EQUAL_TEST_16, 34'h50, 4'h4, 4'h0, 128'h3, 128'h2,
        128'h0, 1'b0, 1'b0, 1'b0, 1'b0, 128'h3},
      '{ACSU_OP_SWAP_EQ8, 34'h68, 4'h1, 4'h0, {64'h11, 64'h22},
        {64'h11, 64'h33}, 128'h11, 1'b1, 1'b1, 1'b0, 1'b1,
        {64'h33, 64'h22}},
      '{ACSU_OP_SWAP_EQ8, 34'h70, 4'h2, 4'h3, {64'h11, 64'h22},
        {64'h22, 64'h44}, 128'h22, 1'b1, 1'b1, 1'b0, 1'b1,
        {64'h11, 64'h44}},
      '{ACSU_OP_SWAP_EQ8, 34'h84, 4'h1, 4'h0, {64'h11, 64'h22},
        {64'h11, 64'h55}, 128'h22, 1'b0, 1'b1, 1'b0, 1'b0,
        {64'h11, 64'h22}},
      '{ACSU_OP_SWAP_EQ8, 34'h3_ffff_ff98, 4'h2, 4'h0, {64'h0, 64'h9},
        {64'h0, 64'h6}, 128'h0, 1'b1, 1'b1, 1'b0, 1'b1,
        {64'h6, 64'h9}},
      '{ACSU_OP_SWAP_Z16, 34'ha0, 4'h5, 4'h1, 128'h0, 128'hcafe,
        128'h0, 1'b1, 1'b1, 1'b0, 1'b1, 128'hcafe},
      '{ACSU_OP_SWAP_Z16, 34'hb2, 4'h1, 4'h0, 128'h1, 128'hcafe,
        128'h1, 1'b0, 1'b1, 1'b0, 1'b0, 128'h1},
      '{7'h00, 34'hc0, 4'h1, 4'h0, 128'h77, 128'h0,
        128'h0, 1'b0, 1'b0, 1'b1, 1'b0, 128'h77}
    };
    do_reset();
    foreach (rows[i]) run_row(rows[i]);
    // Reset while waiting for read data, late data must be ignored
    cut = rows[9];
    u_mem.mem_q[cut.addr[7:4]] = cut.init;
    lat = 4'hc;
    req_valid_i = 1'b1;
    req_cmd_i = cut.cmd;
    req_addr_i = cut.addr;
    req_data_i = cut.imm;
    tick();
    req_valid_i = 1'b0;
    repeat (4) tick();
    do_reset();
    repeat (12) tick();
    chk("idle_after_cut", 2'b10, {req_ready_o, rsp_valid_o});
    chk("mem_after_cut", cut.init, u_mem.mem_q[cut.addr[7:4]]);
    run_row(rows[9]);
    give_verdict();
  end

endmodule // tb_atomic_compare_swap_unit

`default_nettype wire

/* verilog/acsu_alu.sv */
/*
  Combinational datapath of the four atomic operations.
  Assumes the sequencer holds operands stable while results are used.
*/
`timescale 1ns/1ns
`default_nettype none

module acsu_alu
  import acsu_pkg::*;
(
  acsu_op_if.alu op
);

  // ----------------------------------------------------------------------
  // Operand halves
  // ----------------------------------------------------------------------
  logic [ACSU_HALF_W-1:0] mem_sel;
  logic [ACSU_HALF_W-1:0] cmp_val;
  logic [ACSU_HALF_W-1:0] swp_val;
  logic                   imm_lt;

  assign mem_sel = op.sel_hi ? op.mem_data[ACSU_DATA_W-1:ACSU_HALF_W]
                             : op.mem_data[ACSU_HALF_W-1:0]; // RULE9
  assign cmp_val = op.imm_data[ACSU_DATA_W-1:ACSU_HALF_W]; // RULE14
  assign swp_val = op.imm_data[ACSU_HALF_W-1:0]; // RULE14
  assign imm_lt  = op.imm_data < op.mem_data; // RULE1

  // ----------------------------------------------------------------------
  // Operation select
  // ----------------------------------------------------------------------
  always_comb begin
    op.known    = 1'b1;
    op.wr_en    = 1'b0;
    op.wr_data  = op.mem_data;
    op.flag     = 1'b0;
    op.has_data = 1'b1;
    op.rsp_data = op.mem_data; // RULE2
    case (op.cmd)
      ACSU_OP_SWAP_LT16: begin
        op.wr_en   = 1'b1;
        op.wr_data = imm_lt ? op.imm_data : op.mem_data; // RULE1
        op.flag    = imm_lt; // RULE3
      end
      ACSU_OP_EQUAL_TEST_16: begin
        op.flag     = op.imm_data == op.mem_data; // RULE5
        op.has_data = 1'b0; // RULE4
        op.rsp_data = ACSU_ZERO_BLK; // RULE4
      end
      ACSU_OP_SWAP_EQ8: begin
        op.flag     = cmp_val == mem_sel; // RULE8
        op.wr_en    = cmp_val == mem_sel; // RULE8
        op.wr_data  = op.sel_hi
                    ? {swp_val, op.mem_data[ACSU_HALF_W-1:0]}
                    : {op.mem_data[ACSU_DATA_W-1:ACSU_HALF_W], swp_val};
        op.rsp_data = {ACSU_ZERO_HALF, mem_sel}; // RULE10
      end
      ACSU_OP_SWAP_Z16: begin
        op.flag    = op.mem_data == ACSU_ZERO_BLK; // RULE13
        op.wr_en   = op.mem_data == ACSU_ZERO_BLK; // RULE12
        op.wr_data = op.imm_data; // RULE12
      end
      default: begin
        op.known    = 1'b0;
        op.has_data = 1'b0;
        op.rsp_data = ACSU_ZERO_BLK;
      end
    endcase
  end

endmodule // acsu_alu

`default_nettype wire

/* verilog/acsu_rsp_reg.sv */
/*
  Response holding stage with valid and ready handshake.
  Assumes load is only pulsed while no response is pending.
*/
`timescale 1ns/1ns
`default_nettype none

module acsu_rsp_reg
  import acsu_pkg::*;
(
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   load_i,
  input  wire logic                   ready_i,
  acsu_op_if.rsp                      op,
  output logic                        valid_o,
  output logic [ACSU_DATA_W-1:0]      data_o,
  output logic                        flag_o,
  output logic                        has_data_o,
  output logic                        err_o
);

  // ----------------------------------------------------------------------
  // Valid handshake
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      valid_o <= 1'b0;
    end else if (load_i) begin
      valid_o <= 1'b1;
    end else if (ready_i) begin
      valid_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Response fields
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      data_o     <= ACSU_ZERO_BLK;
      flag_o     <= 1'b0;
      has_data_o <= 1'b0;
      err_o      <= 1'b0;
    end else if (load_i) begin
      data_o     <= op.rsp_data;
      flag_o     <= op.known & op.flag;
      has_data_o <= op.known & op.has_data;
      err_o      <= ~op.known;
    end
  end

endmodule // acsu_rsp_reg

`default_nettype wire

/* verilog/acsu_top.sv */
/*
  Atomic read, compare and conditional write sequencer for one vault.
  Assumes requests and the memory port come from logic on ref_clk_i.
*/
// Function
// RULE1 - Swap-if-less writes smaller value, unsigned compare
// RULE2 - Swap-if-less returns original 16-byte operand
// RULE3 - Swap-if-less flag when immediate strictly less
// RULE4 - Equality test: no write, no data
// RULE5 - Equality test flag when operands equal
// RULE6 - Memory operand from aligned 16-byte block
// RULE7 - Requester: compare high, replacement low bytes
// RULE8 - Swap-if-equal writes replacement on match, flags
// RULE9 - Address bit 3 selects upper half
// RULE10 - Swap-if-equal returns operand, upper zeros
// RULE11 - Requester may use zero compare value
// RULE12 - Swap-if-zero writes immediate when memory zero
// RULE13 - Swap-if-zero flags zero, returns original
// RULE14 - Byte bit 7 MSB, byte 15 most significant
// RULE15 - Read, compare and write are indivisible
`timescale 1ns/1ns
`default_nettype none

module acsu_top
  import acsu_pkg::*;
(
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   req_valid_i,
  input  wire logic [ACSU_CMD_W-1:0]  req_cmd_i,
  input  wire logic [ACSU_ADDR_W-1:0] req_addr_i,
  input  wire logic [ACSU_DATA_W-1:0] req_data_i,
  output logic                        req_ready_o,
  output logic                        mem_rd_o,
  output logic                        mem_wr_o,
  output logic                        mem_lock_o,
  output logic [ACSU_ADDR_W-1:0]      mem_addr_o,
  output logic [ACSU_DATA_W-1:0]      mem_wdata_o,
  input  wire logic [ACSU_DATA_W-1:0] mem_rdata_i,
  input  wire logic                   mem_rvalid_i,
  output logic                        rsp_valid_o,
  output logic [ACSU_DATA_W-1:0]      rsp_data_o,
  output logic                        rsp_flag_o,
  output logic                        rsp_has_data_o,
  output logic                        rsp_err_o,
  input  wire logic                   rsp_ready_i
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  acsu_state_t            state_q;
  logic [ACSU_CMD_W-1:0]  cmd_q;
  logic [ACSU_ADDR_W-1:0] addr_q;
  logic [ACSU_DATA_W-1:0] imm_q;
  logic [ACSU_DATA_W-1:0] mem_q;
  logic                   ready_q;
  logic                   rd_q;
  logic                   wr_q;
  logic                   lock_q;
  logic [ACSU_ADDR_W-1:0] maddr_q;
  logic [ACSU_DATA_W-1:0] wdata_q;
  logic                   accept;
  logic                   known_req;
  logic                   rsp_done;
  logic                   rsp_valid;

  acsu_op_if op ();

  assign known_req = (req_cmd_i == ACSU_OP_SWAP_LT16)
                   | (req_cmd_i == ACSU_OP_EQUAL_TEST_16)
                   | (req_cmd_i == ACSU_OP_SWAP_EQ8)
                   | (req_cmd_i == ACSU_OP_SWAP_Z16);
  assign accept    = req_valid_i & ready_q & (state_q == ST_IDLE);
  assign rsp_done  = (state_q == ST_RESP) & rsp_valid & rsp_ready_i;

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (accept) begin
            state_q <= known_req ? ST_WAIT : ST_EXEC;
          end
        end
        ST_WAIT: begin
          if (mem_rvalid_i) begin
            state_q <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          state_q <= ST_RESP;
        end
        ST_RESP: begin
          if (rsp_done) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Request capture and intake gate
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cmd_q  <= '0;
      addr_q <= '0;
      imm_q  <= ACSU_ZERO_BLK;
    end else if (accept) begin
      cmd_q  <= req_cmd_i;
      addr_q <= req_addr_i;
      imm_q  <= req_data_i; // RULE14
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ready_q <= 1'b1;
    end else if (accept) begin
      ready_q <= 1'b0; // RULE15
    end else if (rsp_done) begin
      ready_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Memory port
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rd_q    <= 1'b0;
      maddr_q <= '0;
    end else begin
      rd_q <= accept & known_req;
      if (accept) begin
        maddr_q <= {req_addr_i[ACSU_ADDR_W-1:ACSU_BLK_LSB],
                    ACSU_BLK_PAD}; // RULE6
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mem_q <= ACSU_ZERO_BLK;
    end else if ((state_q == ST_WAIT) && mem_rvalid_i) begin
      mem_q <= mem_rdata_i; // RULE6
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wr_q    <= 1'b0;
      wdata_q <= ACSU_ZERO_BLK;
    end else begin
      wr_q <= (state_q == ST_EXEC) & op.wr_en & op.known;
      if (state_q == ST_EXEC) begin
        wdata_q <= op.wr_data;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      lock_q <= 1'b0;
    end else if (accept && known_req) begin
      lock_q <= 1'b1; // RULE15
    end else if (rsp_done) begin
      lock_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Datapath and response stage
  // ----------------------------------------------------------------------
  assign op.cmd      = cmd_q;
  assign op.sel_hi   = addr_q[ACSU_SEL_BIT]; // RULE9
  assign op.mem_data = mem_q;
  assign op.imm_data = imm_q;

  acsu_alu u_alu (
    .op (op.alu)
  );

  acsu_rsp_reg u_rsp (
    .ref_clk_i  (ref_clk_i),
    .rst_i      (rst_i),
    .load_i     (state_q == ST_EXEC),
    .ready_i    (rsp_ready_i),
    .op         (op.rsp),
    .valid_o    (rsp_valid),
    .data_o     (rsp_data_o),
    .flag_o     (rsp_flag_o),
    .has_data_o (rsp_has_data_o),
    .err_o      (rsp_err_o)
  );

  assign req_ready_o = ready_q;
  assign mem_rd_o    = rd_q;
  assign mem_wr_o    = wr_q;
  assign mem_lock_o  = lock_q;
  assign mem_addr_o  = maddr_q;
  assign mem_wdata_o = wdata_q;
  assign rsp_valid_o = rsp_valid;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_exec(logic [ACSU_CMD_W-1:0] c);
    (state_q == ST_EXEC) && (cmd_q == c);
  endsequence

  sequence s_accept_known;
    accept && known_req;
  endsequence

  property p_lt_write;
    s_exec(ACSU_OP_SWAP_LT16) |=> mem_wr_o && (mem_wdata_o ==
      (($past(imm_q) < $past(mem_q)) ? $past(imm_q) : $past(mem_q)));
  endproperty
  a_lt_write: assert property (p_lt_write) // RULE1
    else $error("swap-if-less wrote wrong value");

  property p_lt_rsp;
    s_exec(ACSU_OP_SWAP_LT16) |=> rsp_valid_o && rsp_has_data_o
      && (rsp_data_o == $past(mem_q));
  endproperty
  a_lt_rsp: assert property (p_lt_rsp) // RULE2
    else $error("swap-if-less response data wrong");

  property p_lt_flag;
    s_exec(ACSU_OP_SWAP_LT16) |=>
      rsp_flag_o == ($past(imm_q) < $past(mem_q));
  endproperty
  a_lt_flag: assert property (p_lt_flag) // RULE3
    else $error("swap-if-less flag wrong");

  property p_eq_nowr;
    s_exec(ACSU_OP_EQUAL_TEST_16) |=> !mem_wr_o && !rsp_has_data_o
      && (rsp_data_o == ACSU_ZERO_BLK);
  endproperty
  a_eq_nowr: assert property (p_eq_nowr) // RULE4
    else $error("equality test wrote memory or returned data");

  property p_eq_flag;
    s_exec(ACSU_OP_EQUAL_TEST_16) |=> rsp_flag_o == ($past(imm_q) == $past(mem_q));
  endproperty
  a_eq_flag: assert property (p_eq_flag) // RULE5
    else $error("equality test flag wrong");

  property p_addr;
    s_accept_known |=> mem_rd_o && mem_lock_o
      && (mem_addr_o[ACSU_BLK_LSB-1:0] == ACSU_BLK_PAD)
      && (mem_addr_o[ACSU_ADDR_W-1:ACSU_BLK_LSB]
          == $past(req_addr_i[ACSU_ADDR_W-1:ACSU_BLK_LSB]));
  endproperty
  a_addr: assert property (p_addr) // RULE6
    else $error("memory read address not the aligned block");

  property p_eq8_flag;
    s_exec(ACSU_OP_SWAP_EQ8) |=> (rsp_flag_o == mem_wr_o) && (rsp_flag_o ==
      ($past(imm_q[ACSU_DATA_W-1:ACSU_HALF_W])
       == rsp_data_o[ACSU_HALF_W-1:0]));
  endproperty
  a_eq8_flag: assert property (p_eq8_flag) // RULE8
    else $error("swap-if-equal flag or write wrong");

  property p_eq8_rsp;
    s_exec(ACSU_OP_SWAP_EQ8) |=>
      (rsp_data_o[ACSU_DATA_W-1:ACSU_HALF_W] == ACSU_ZERO_HALF)
      && (rsp_data_o[ACSU_HALF_W-1:0] == ($past(addr_q[ACSU_SEL_BIT])
          ? $past(mem_q[ACSU_DATA_W-1:ACSU_HALF_W])
          : $past(mem_q[ACSU_HALF_W-1:0])));
  endproperty
  a_eq8_rsp: assert property (p_eq8_rsp) // RULE9 RULE10
    else $error("swap-if-equal response operand wrong");

  property p_z16;
    s_exec(ACSU_OP_SWAP_Z16) |=>
      (rsp_flag_o == ($past(mem_q) == ACSU_ZERO_BLK))
      && (mem_wr_o == rsp_flag_o) && (rsp_data_o == $past(mem_q))
      && (!mem_wr_o || (mem_wdata_o == $past(imm_q)));
  endproperty
  a_z16: assert property (p_z16) // RULE12 RULE13
    else $error("swap-if-zero result wrong");

  property p_atomic;
    (mem_rd_o || mem_wr_o) |-> mem_lock_o && !req_ready_o;
  endproperty
  a_atomic: assert property (p_atomic) // RULE15
    else $error("memory access outside locked sequence");

  property p_rsp_hold;
    rsp_valid_o && !rsp_ready_i |=> rsp_valid_o && $stable(rsp_data_o)
      && $stable(rsp_flag_o);
  endproperty
  a_rsp_hold: assert property (p_rsp_hold) // RULE2
    else $error("response changed while stalled");

endmodule // acsu_top

`default_nettype wire
